// ===== src/fofu_unit.sv
`timescale 1ns/1ps
module fofu_unit
    import fofu_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    // Command from the host core.
    input  wire logic                   cmd_valid_i,
    input  wire logic [1:0]             cmd_op_i,
    input  wire logic [1:0]             cmd_fmt_i,
    // Operand words from memory, most significant first.
    input  wire logic                   word_in_valid_i,
    input  wire logic [FOFU_MEM_W-1:0]  word_in_i,
    // Arithmetic result written into the working word by the core.
    input  wire logic                   res_valid_i,
    input  wire logic                   res_sign_i,
    input  wire logic [FOFU_EXP_W-1:0]  res_exp_i,
    input  wire logic [FOFU_FRAC_W-1:0] res_frac_i,
    // Words back toward memory, most significant first.
    output logic                        word_out_valid_o,
    output logic [FOFU_MEM_W-1:0]       word_out_o,
    // Working word visible to the core.
    output logic                        wk_sign_o,
    output logic [FOFU_EXP_W-1:0]       wk_exp_o,
    output logic [FOFU_FRAC_W-1:0]      wk_frac_o,
    // Status and exceptions.
    output logic                        busy_o,
    output logic                        done_o,
    output logic                        zero_o,
    output logic                        neg_o,
    output logic                        exc_fmt_o,
    output logic                        exc_ovf_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fofu_state_t               state_r,  state_nxt;
    fofu_fmt_t                 fmt_r,    fmt_nxt;
    logic [2:0]                cnt_r,    cnt_nxt;
    logic [63:0]               raw_r,    raw_nxt;
    logic                      sign_r,   sign_nxt;
    logic [FOFU_EXP_W-1:0]     exp_r,    exp_nxt;
    logic [FOFU_FRAC_W-1:0]    frac_r,   frac_nxt;
    logic                      wov_r,    wov_nxt;
    logic [FOFU_MEM_W-1:0]     wout_r,   wout_nxt;
    logic                      done_r,   done_nxt;
    logic                      efmt_r,   efmt_nxt;
    logic                      eovf_r,   eovf_nxt;
    logic                      zero_r,   zero_nxt;
    logic [5:0]                nrm_r,    nrm_nxt;
    logic                      busy_r,   busy_nxt;

    // Left-aligned 64-bit packed image of the working word; its top 16 bits go out first.
    function automatic logic [63:0] pack(input fofu_fmt_t f, input logic s,
                                         input logic [7:0] e, input logic [63:0] m);
        logic [63:0] p;
        p = 64'h0;
        case (f)
            FOFU_FMT_SHORT:  p = {m[15:0], 48'h0};
            FOFU_FMT_LONG:   p = {m[31:0], 32'h0};
            // Hidden bit 62 is left behind; only bits below it are stored.
            FOFU_FMT_SINGLE: p = {s, e, m[61:39], 32'h0};
            default:         p = {s, e, m[61:7]};
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        fmt_nxt   = fmt_r;
        cnt_nxt   = cnt_r;
        raw_nxt   = raw_r;
        sign_nxt  = sign_r;
        exp_nxt   = exp_r;
        frac_nxt  = frac_r;
        wov_nxt   = 1'b0;
        wout_nxt  = wout_r;
        done_nxt  = 1'b0;
        efmt_nxt  = efmt_r;
        eovf_nxt  = eovf_r;
        zero_nxt  = zero_r;
        nrm_nxt   = nrm_r;
        case (state_r)
            FOFU_ST_IDLE, FOFU_ST_HOLD: begin
                if (cmd_valid_i) begin
                    // The format field is two bits, so all four codes are legal formats.
                    fmt_nxt  = fofu_fmt_t'(cmd_fmt_i);
                    cnt_nxt  = fofu_words(fofu_fmt_t'(cmd_fmt_i));
                    efmt_nxt = 1'b0;
                    eovf_nxt = 1'b0;
                    case (fofu_op_t'(cmd_op_i))
                        FOFU_OP_LOAD: begin
                            raw_nxt   = 64'h0;
                            state_nxt = FOFU_ST_LOAD;
                        end
                        FOFU_OP_STORE: begin
                            raw_nxt   = pack(fofu_fmt_t'(cmd_fmt_i), sign_r, exp_r, frac_r);
                            state_nxt = FOFU_ST_STORE;
                        end
                        FOFU_OP_NEGATE: begin
                            // Integers cannot be negated by a sign flip.
                            if (cmd_fmt_i[1]) begin
                                sign_nxt = ~sign_r;
                            end else begin
                                efmt_nxt = 1'b1;
                            end
                            done_nxt = 1'b1;
                        end
                        default: efmt_nxt = 1'b1;
                    endcase
                end else if (res_valid_i) begin
                    sign_nxt  = res_sign_i;
                    exp_nxt   = res_exp_i;
                    frac_nxt  = res_frac_i;
                    nrm_nxt   = FOFU_NORM_MAX;
                    state_nxt = FOFU_ST_NORM;
                end
            end
            FOFU_ST_LOAD: begin
                if (word_in_valid_i) begin
                    // First word holds the sign, and for floats the exponent; later ones descend.
                    raw_nxt = {raw_r[47:0], word_in_i};
                    cnt_nxt = cnt_r - 3'h1;
                    if (cnt_r == 3'h1) begin
                        state_nxt = FOFU_ST_HOLD;
                        done_nxt  = 1'b1;
                        case (fmt_r)
                            FOFU_FMT_SHORT: begin
                                // Sign taken from the top bit of the word.
                                sign_nxt = word_in_i[15];
                                exp_nxt  = FOFU_EXP_ZERO;
                                frac_nxt = {{48{word_in_i[15]}}, word_in_i};
                                zero_nxt = (word_in_i == 16'h0);
                            end
                            FOFU_FMT_LONG: begin
                                sign_nxt = raw_r[15];
                                exp_nxt  = FOFU_EXP_ZERO;
                                frac_nxt = {{32{raw_r[15]}}, raw_r[15:0], word_in_i};
                                zero_nxt = ({raw_r[15:0], word_in_i} == 32'h0);
                            end
                            FOFU_FMT_SINGLE: begin
                                sign_nxt = raw_r[15];
                                exp_nxt  = raw_r[14:7];
                                // Overflow clear, hidden bit restored.
                                frac_nxt = {2'b01, raw_r[6:0], word_in_i, 39'h0};
                                zero_nxt = (raw_r[14:7] == FOFU_EXP_ZERO);
                                if (raw_r[14:7] == FOFU_EXP_ZERO) begin
                                    frac_nxt = 64'h0;
                                end
                            end
                            default: begin
                                sign_nxt = raw_r[47];
                                exp_nxt  = raw_r[46:39];
                                frac_nxt = {2'b01, raw_r[38:0], word_in_i, 7'h0};
                                zero_nxt = (raw_r[46:39] == FOFU_EXP_ZERO);
                                if (raw_r[46:39] == FOFU_EXP_ZERO) begin
                                    frac_nxt = 64'h0;
                                end
                            end
                        endcase
                    end
                end
            end
            FOFU_ST_NORM: begin
                // One shift per cycle; an all-zero fraction is cleared at once, and the step limit bounds the left shifts.
                if (frac_r[FOFU_OVF_POS]) begin
                    frac_nxt = {1'b0, frac_r[63:1]};
                    exp_nxt  = exp_r + 8'h01;
                    eovf_nxt = (exp_r == 8'hff);
                end else if (frac_r == 64'h0 || exp_r == FOFU_EXP_ZERO) begin
                    frac_nxt  = 64'h0;
                    exp_nxt   = FOFU_EXP_ZERO;
                    zero_nxt  = 1'b1;
                    done_nxt  = 1'b1;
                    state_nxt = FOFU_ST_HOLD;
                end else if (!frac_r[FOFU_HID_POS] && nrm_r != 6'h0) begin
                    frac_nxt = {frac_r[62:0], 1'b0};
                    exp_nxt  = exp_r - 8'h01;
                    nrm_nxt  = nrm_r - 6'h01;
                end else begin
                    zero_nxt  = 1'b0;
                    done_nxt  = 1'b1;
                    state_nxt = FOFU_ST_HOLD;
                end
            end
            FOFU_ST_STORE: begin
                wout_nxt = raw_r[63:48];
                wov_nxt  = 1'b1;
                raw_nxt  = {raw_r[47:0], 16'h0};
                cnt_nxt  = cnt_r - 3'h1;
                if (cnt_r == 3'h1) begin
                    done_nxt  = 1'b1;
                    state_nxt = FOFU_ST_HOLD;
                end
            end
            default: state_nxt = FOFU_ST_IDLE;
        endcase
        // Busy follows the next state so the pin is driven straight from a flop.
        busy_nxt = (state_nxt == FOFU_ST_LOAD) || (state_nxt == FOFU_ST_NORM)
                   || (state_nxt == FOFU_ST_STORE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= FOFU_ST_IDLE;
            fmt_r   <= FOFU_FMT_SHORT;
            cnt_r   <= 3'h0;
            raw_r   <= 64'h0;
            sign_r  <= 1'b0;
            exp_r   <= 8'h00;
            frac_r  <= 64'h0;
            wov_r   <= 1'b0;
            wout_r  <= 16'h0;
            done_r  <= 1'b0;
            efmt_r  <= 1'b0;
            eovf_r  <= 1'b0;
            zero_r  <= 1'b1;
            nrm_r   <= 6'h0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fmt_r   <= fmt_nxt;
            cnt_r   <= cnt_nxt;
            raw_r   <= raw_nxt;
            sign_r  <= sign_nxt;
            exp_r   <= exp_nxt;
            frac_r  <= frac_nxt;
            wov_r   <= wov_nxt;
            wout_r  <= wout_nxt;
            done_r  <= done_nxt;
            efmt_r  <= efmt_nxt;
            eovf_r  <= eovf_nxt;
            zero_r  <= zero_nxt;
            nrm_r   <= nrm_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign word_out_valid_o = wov_r;
    assign word_out_o       = wout_r;
    assign wk_sign_o        = sign_r;
    assign wk_exp_o         = exp_r;
    assign wk_frac_o        = frac_r;
    assign busy_o           = busy_r;
    assign done_o           = done_r;
    assign zero_o           = zero_r;
    assign neg_o            = sign_r;
    assign exc_fmt_o        = efmt_r;
    assign exc_ovf_o        = eovf_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence float_load_last_s;
        state_r == FOFU_ST_LOAD && word_in_valid_i && cnt_r == 3'h1 && fmt_r[1];
    endsequence

    norm_shift_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == FOFU_ST_NORM && frac_r[63] |=> frac_r[62] == 1'b1 && !frac_r[63]
        && exp_r == $past(exp_r) + 8'h01)
        else $error("overflow renormalize wrong");

    norm_result_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == FOFU_ST_NORM && state_nxt == FOFU_ST_HOLD && !zero_nxt
        |=> !frac_r[63] && frac_r[62])
        else $error("normalized fraction bad");

    hidden_restore_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        float_load_last_s |=> zero_r || frac_r[63:62] == 2'b01)
        else $error("hidden bit not restored");

    zero_exp_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        float_load_last_s ##1 exp_r == 8'h00 |-> zero_r && frac_r == 64'h0)
        else $error("zero exponent not zero");

    negate_sign_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_r == FOFU_ST_IDLE || state_r == FOFU_ST_HOLD) && cmd_valid_i
        && cmd_op_i == 2'b11 && cmd_fmt_i[1]
        |=> sign_r != $past(sign_r) && $stable(frac_r) && $stable(exp_r))
        else $error("negate changed magnitude");

    int_sign_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_r == FOFU_ST_LOAD && word_in_valid_i && fmt_r == FOFU_FMT_SHORT
        |=> sign_r == $past(word_in_i[15]))
        else $error("short sign wrong");

    store_first_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_r == FOFU_ST_IDLE || state_r == FOFU_ST_HOLD) && cmd_valid_i
        && cmd_op_i == 2'b10 && cmd_fmt_i == 2'b11
        |=> ##1 word_out_valid_o && word_out_o[15] == $past(sign_r, 2)
        && word_out_o[14:7] == $past(exp_r, 2))
        else $error("first stored word wrong");

    store_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_r == FOFU_ST_IDLE || state_r == FOFU_ST_HOLD) && cmd_valid_i
        && cmd_op_i == 2'b10 && cmd_fmt_i == 2'b11
        |=> ##1 word_out_valid_o [*3] ##1 word_out_valid_o && done_o ##1 !word_out_valid_o)
        else $error("double store length wrong");

endmodule // fofu_unit

// ===== src/fofu_pkg.sv
package fofu_pkg;

    // ------------------------------------------------------------
    // Operand formats and the transfer sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FOFU_FMT_SHORT  = 2'b00,
        FOFU_FMT_LONG   = 2'b01,
        FOFU_FMT_SINGLE = 2'b10,
        FOFU_FMT_DOUBLE = 2'b11
    } fofu_fmt_t;

    typedef enum logic [2:0] {
        FOFU_ST_IDLE   = 3'b000,
        FOFU_ST_LOAD   = 3'b001,
        FOFU_ST_NORM   = 3'b010,
        FOFU_ST_HOLD   = 3'b011,
        FOFU_ST_STORE  = 3'b100
    } fofu_state_t;

    typedef enum logic [1:0] {
        FOFU_OP_NONE   = 2'b00,
        FOFU_OP_LOAD   = 2'b01,
        FOFU_OP_STORE  = 2'b10,
        FOFU_OP_NEGATE = 2'b11
    } fofu_op_t;

    // ------------------------------------------------------------
    // Working word layout and widths
    // ------------------------------------------------------------
    localparam int          FOFU_MEM_W      = 16;
    localparam int          FOFU_FRAC_W     = 64;
    localparam int          FOFU_EXP_W      = 8;
    localparam int          FOFU_OVF_POS    = 63;
    localparam int          FOFU_HID_POS    = 62;
    localparam int          FOFU_SF_FRAC_W  = 23;
    localparam int          FOFU_DF_FRAC_W  = 55;
    localparam logic [7:0]  FOFU_EXP_BIAS   = 8'h80;
    localparam logic [7:0]  FOFU_EXP_ZERO   = 8'h00;
    localparam logic [2:0]  FOFU_WORDS_I    = 3'h1;
    localparam logic [2:0]  FOFU_WORDS_L    = 3'h2;
    localparam logic [2:0]  FOFU_WORDS_F    = 3'h2;
    localparam logic [2:0]  FOFU_WORDS_D    = 3'h4;
    localparam logic [5:0]  FOFU_NORM_MAX   = 6'h3f;

    // Number of 16-bit memory words that make up one operand.
    function automatic logic [2:0] fofu_words(input fofu_fmt_t f);
        case (f)
            FOFU_FMT_SHORT:  fofu_words = FOFU_WORDS_I;
            FOFU_FMT_LONG:   fofu_words = FOFU_WORDS_L;
            FOFU_FMT_SINGLE: fofu_words = FOFU_WORDS_F;
            default:         fofu_words = FOFU_WORDS_D;
        endcase
    endfunction

endpackage

// ===== test/fofu_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Memory side model that feeds operand words to the unit
// ------------------------------------------------------------
module fofu_mem_model (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Request from the bench: word count, left-aligned data, idle gap before each word.
    input  wire logic        start_i,
    input  wire logic [2:0]  count_i,
    input  wire logic [63:0] data_i,
    input  wire logic [1:0]  gap_i,
    // Word stream toward the unit.
    output logic             word_in_valid_o,
    output logic [15:0]      word_in_o
);
    logic [2:0]  left_r;
    logic [63:0] buf_r;
    logic [1:0]  wait_r;

    // Between words the data line flips every idle cycle, so a unit that samples without the
    // strobe reads the inverse of the last word on odd idle cycles and a copy on even ones.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            left_r <= 3'h0;
            buf_r <= 64'h0;
            wait_r <= 2'h0;
            word_in_valid_o <= 1'b0;
            word_in_o <= 16'h0;
        end else begin
            if (left_r != 3'h0 && wait_r == 2'h0 && !start_i) begin
                word_in_valid_o <= 1'b1;
                word_in_o       <= buf_r[63:48];
                buf_r           <= {buf_r[47:0], 16'h0};
                left_r          <= left_r - 3'h1;
                wait_r          <= gap_i;
            end else begin
                word_in_valid_o <= 1'b0;
                word_in_o       <= ~word_in_o;
                if (start_i) begin
                    left_r <= count_i;
                    buf_r  <= data_i;
                    wait_r <= gap_i;
                end else if (left_r != 3'h0) begin
                    wait_r <= wait_r - 2'h1;
                end
            end
        end
    end
endmodule // fofu_mem_model

// ===== test/test_fofu_unit.sv
`timescale 1ns/1ps
module test_fofu_unit;
    import fofu_pkg::*;

    // ------------------------------------------------------------
    // Signals and expectation layout {ovf, neg, zero, exc, sign, exp, frac}
    // ------------------------------------------------------------
    localparam logic [79:0] m_all  = {3'h0, {77{1'b1}}};
    localparam logic [79:0] m_int  = {4'h1, 4'b0010, {72{1'b1}}};
    localparam logic [79:0] m_zero = {4'h1, 4'b0110, {72{1'b1}}};
    localparam logic [79:0] m_exc  = {4'h0, 4'b0010, 72'h0};
    localparam logic [79:0] m_word = 80'hffff;
    logic         clk_i, reset_n_i, cmd_valid_i, word_in_valid_i, res_valid_i, res_sign_i;
    logic [1:0]   cmd_op_i, cmd_fmt_i, mdl_gap;
    logic [15:0]  word_in_i, word_out_o;
    logic [7:0]   res_exp_i, wk_exp_o;
    logic [63:0]  res_frac_i, wk_frac_o, mdl_data;
    logic         word_out_valid_o, wk_sign_o, busy_o, done_o, zero_o, neg_o;
    logic         exc_fmt_o, exc_ovf_o, mdl_start, stray_ok;
    logic [2:0]   mdl_count;
    logic [159:0] notes[$];
    logic [79:0]  cur_w, cur_m;
    int           bad_count, comparisons;

    fofu_unit uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_fmt_i(cmd_fmt_i), .word_in_valid_i(word_in_valid_i),
        .word_in_i(word_in_i), .res_valid_i(res_valid_i), .res_sign_i(res_sign_i),
        .res_exp_i(res_exp_i), .res_frac_i(res_frac_i), .word_out_valid_o(word_out_valid_o),
        .word_out_o(word_out_o), .wk_sign_o(wk_sign_o), .wk_exp_o(wk_exp_o),
        .wk_frac_o(wk_frac_o), .busy_o(busy_o), .done_o(done_o), .zero_o(zero_o),
        .neg_o(neg_o), .exc_fmt_o(exc_fmt_o), .exc_ovf_o(exc_ovf_o));
    fofu_mem_model mem_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(mdl_start),
        .count_i(mdl_count), .data_i(mdl_data), .gap_i(mdl_gap),
        .word_in_valid_o(word_in_valid_i), .word_in_o(word_in_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [79:0] seen, input logic [79:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [79:0] ww(input logic z, input logic x, input logic s,
                                       input logic [7:0] e, input logic [63:0] fr);
        return {4'h0, s, z, x, s, e, fr};
    endfunction
    function automatic int nwords(input logic [1:0] f);
        return (f == 2'h0) ? 1 : ((f == 2'h3) ? 4 : 2);
    endfunction
    task automatic note(input logic [79:0] m, input logic [79:0] v);
        notes.push_back({m, v});
    endtask
    // A result with no note pending is wrong, except while a refused command is probed.
    task automatic take(input logic [79:0] seen);
        logic [159:0] e;
        if (notes.size() == 0) begin
            // Bit 79 is always zero in a seen value, so this always counts a mismatch.
            if (!stray_ok) check(seen, {1'b1, seen[78:0]});
        end else begin
            e = notes.pop_front();
            check(seen & e[159:80], e[79:0] & e[159:80]);
        end
    endtask
    always @(negedge clk_i) begin
        if (word_out_valid_o === 1'b1) take({64'h0, word_out_o});
        if (done_o === 1'b1) begin
            take({3'h0, exc_ovf_o, neg_o, zero_o, exc_fmt_o, wk_sign_o, wk_exp_o,
                  wk_frac_o});
        end
    end
    // Waits for completion, then for idle, since a command seen while busy is dropped.
    task automatic finish_wait;
        int n;
        n = 0;
        do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 200);
        while (busy_o !== 1'b0 && n < 200) begin @(negedge clk_i); n++; end
        if (n >= 200) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic issue(input logic [1:0] op, input logic [1:0] f, input logic [63:0] d,
                         input logic [1:0] g, input logic w);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_fmt_i <= f;
        mdl_start <= (op == 2'h1);
        mdl_count <= 3'(nwords(f));
        mdl_data <= d;
        mdl_gap <= g;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        mdl_start <= 1'b0;
        if (w) finish_wait();
    endtask
    task automatic do_load(input logic [1:0] f, input logic [63:0] d, input logic [1:0] g);
        case (f)
            2'h0: cur_w = ww(1'b0, 1'b0, d[63], 8'h00, {{48{d[63]}}, d[63:48]});
            2'h1: cur_w = ww(1'b0, 1'b0, d[63], 8'h00, {{32{d[63]}}, d[63:32]});
            2'h2: cur_w = ww(1'b0, 1'b0, d[63], d[62:55], {2'b01, d[54:32], 39'h0});
            default: cur_w = ww(1'b0, 1'b0, d[63], d[62:55], {2'b01, d[54:0], 7'h0});
        endcase
        cur_m = f[1] ? m_all : m_int;
        if (f[1] && d[62:55] == 8'h00) begin
            cur_w = ww(1'b1, 1'b0, 1'b0, 8'h00, 64'h0);
            cur_m = m_zero;
        end
        note(cur_m, cur_w);
        issue(2'h1, f, d, g, 1'b1);
    endtask
    task automatic do_store(input logic [1:0] f, input logic [63:0] d);
        for (int i = 0; i < nwords(f); i++) note(m_word, {64'h0, d[63-16*i -: 16]});
        note(cur_m, cur_w);
        issue(2'h2, f, 64'h0, 2'h0, 1'b1);
    endtask
    task automatic do_negate(input logic [1:0] f);
        if (f[1]) begin
            cur_w = cur_w ^ {4'h0, 4'b1001, 72'h0};
            note(cur_m, cur_w);
        end else begin
            note(m_exc, m_exc);
        end
        issue(2'h3, f, 64'h0, 2'h0, 1'b1);
    endtask
    task automatic do_res(input logic s, input logic [7:0] e, input logic [63:0] fr);
        logic [63:0] nf;
        logic [7:0]  ne;
        logic        ov;
        nf = fr;
        ne = e;
        ov = 1'b0;
        if (nf[63]) begin
            nf = nf >> 1;
            ov = (ne == 8'hff);
            ne = ne + 8'h01;
        end else begin
            while (nf[62] == 1'b0) begin
                nf = nf << 1;
                ne = ne - 8'h01;
            end
        end
        // A wrapped exponent leaves a clean zero; the refused probe's flag still stands.
        if (ne == 8'h00) nf = 64'h0;
        note(m_all, ww(ne == 8'h00, 1'b1, s, ne, nf) | {3'h0, ov, 76'h0});
        @(posedge clk_i);
        res_valid_i <= 1'b1;
        res_sign_i <= s;
        res_exp_i <= e;
        res_frac_i <= fr;
        @(posedge clk_i);
        res_valid_i <= 1'b0;
        finish_wait();
    endtask

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        logic [63:0] d;
        {reset_n_i, cmd_valid_i, cmd_op_i, cmd_fmt_i, res_valid_i, res_sign_i} = '0;
        {res_exp_i, res_frac_i, mdl_start, mdl_count, mdl_data, mdl_gap, stray_ok} = '0;
        void'($urandom(32'hd08b));
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // Every format, slow and prompt word delivery, then a zero exponent pass.
        for (int rep = 0; rep < 4; rep++) begin
            for (int f = 0; f < 4; f++) begin
                d = {$urandom, $urandom};
                if (f >= 2) d[62:55] = (rep == 3) ? 8'h00 : (d[62:55] | 8'h01);
                do_load(f[1:0], d, rep[1:0]);
                if (rep != 3 || f < 2) begin
                    do_store(f[1:0], d);
                    do_negate(f[1:0]);
                    do_store(f[1:0], (f >= 2) ? (d ^ {1'b1, 63'h0}) : d);
                end
            end
        end
        stray_ok = 1'b1;
        issue(2'h0, 2'h2, 64'h0, 2'h0, 1'b0);
        repeat (3) @(negedge clk_i);
        check({79'h0, exc_fmt_o}, 80'h1);
        stray_ok = 1'b0;
        repeat (2) @(negedge clk_i);
        do_res(1'b0, 8'h80, {1'b1, 31'($urandom), 32'($urandom)});
        do_res(1'b1, 8'h90, {3'b000, 29'($urandom) | 29'h1, 32'($urandom)});
        do_res(1'b0, 8'h41, {2'b01, 30'($urandom), 32'($urandom)});
        do_res(1'b0, 8'hff, {1'b1, 31'($urandom), 32'($urandom)});
        repeat (3) @(negedge clk_i);
        check(80'(notes.size()), 80'h0);
        close_out();
    end
endmodule // test_fofu_unit
